// ### sidf_pkg.sv
// package: shared constants and types of the parallel-stream inverse transform
package sidf_pkg;

  // ==========================================================
  // frame and stream geometry
  localparam int N_PTS = 1536;
  localparam int N_STR = 6;
  localparam int BLK_SMP = 256;
  localparam int LANES = 4;
  localparam int BEATS = BLK_SMP / LANES;
  localparam int BUS_W = 128;
  localparam int IDX_W = 11;
  localparam int CNT_W = 7;
  localparam int ADR_W = 24;

  // ==========================================================
  // sample formats and arithmetic widths
  localparam int SMP_W = 16;
  localparam int INT_W = 32;
  localparam int TW_W = 16;
  localparam int TW_FRAC = 14;
  localparam real TW_ONE = 2.0 ** TW_FRAC;
  localparam real PI = 3.14159265358979;
  localparam int PROD_W = INT_W + TW_W;
  localparam int ACC_W = PROD_W + 2;
  localparam int OUT_SHIFT = 11;

  // ==========================================================
  // stage plan: radix, element span and group count per pass
  localparam int N_STG = 6;
  localparam int STG_W = 3;
  localparam int STG_RADIX [N_STG] = '{4, 4, 4, 4, 2, 3};
  localparam int STG_SPAN [N_STG] = '{1, 4, 16, 64, 256, 512};
  localparam int STG_M [N_STG] = '{384, 96, 24, 6, 3, 1};

  // ==========================================================
  // compute sequencer states, gray coded along idle-run-finish
  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_RUN = 2'h1,
    C_FIN = 2'h3
  } sidf_cstate_t;

endpackage

// ### sidf_cmul.sv
// file: twiddle table and complex multiplier of the transform engine
`timescale 1ns/100ps

module sidf_cmul
  import sidf_pkg::*;
(
  // twiddle exponent, in units of one 1536th of a turn
  input wire logic [IDX_W-1:0] expo,
  // operand, real and imaginary
  input wire logic signed [INT_W-1:0] x_re,
  input wire logic signed [INT_W-1:0] x_im,
  // product scaled by the twiddle unit
  output logic signed [PROD_W-1:0] p_re,
  output logic signed [PROD_W-1:0] p_im
);

  // ==========================================================
  // twiddle table
  logic signed [TW_W-1:0] tw_cos [N_PTS];
  logic signed [TW_W-1:0] tw_sin [N_PTS];
  logic signed [TW_W-1:0] c_v;
  logic signed [TW_W-1:0] s_v;

  // positive angle gives the inverse direction (see RL9)
  for (genvar k = 0; k < N_PTS; k++) begin : g_tw
    assign tw_cos[k] = TW_W'($rtoi(TW_ONE * $cos(2.0 * PI * k / N_PTS)));
    assign tw_sin[k] = TW_W'($rtoi(TW_ONE * $sin(2.0 * PI * k / N_PTS)));
  end

  assign c_v = tw_cos[expo];
  assign s_v = tw_sin[expo];

  // ==========================================================
  // complex product; widths are exact so nothing is lost here
  assign p_re = PROD_W'(x_re * c_v) - PROD_W'(x_im * s_v);
  assign p_im = PROD_W'(x_re * s_v) + PROD_W'(x_im * c_v);

endmodule

// ### sidf_top.sv
// file: parallel-stream 1536-point inverse transform, streams and engine
`timescale 1ns/100ps

// Overview of operation
// (RL1) mixed radix 2/3/4 passes, no direct sum
// (RL2) three 512-point transforms, then 3-point combines
// (RL3) 512-point part: four radix-4, one radix-2
// (RL4) 16-bit complex edges, 32-bit complex inside
// (RL5) each stream bus is 128 bits wide
// (RL6) six input and six output streams
// (RL7) transfers overlap compute via banked buffers
// (RL8) frame is six blocks of 256 samples
// (RL9) positive twiddle sign, fixed output shift
module sidf_top
  import sidf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // input streams
  input wire logic [BUS_W-1:0] in_tdata [N_STR],
  input wire logic [N_STR-1:0] in_tvalid,
  output logic [N_STR-1:0] in_tready,
  // output streams
  output logic [BUS_W-1:0] out_tdata [N_STR],
  output logic [N_STR-1:0] out_tvalid,
  output logic [N_STR-1:0] out_tlast,
  input wire logic [N_STR-1:0] out_tready
);

  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  // assert at once, release after two edges
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // ==========================================================
  // storage: two input banks, two work banks, two output banks
  logic [BUS_W-1:0] in_mem [2][N_STR][BEATS];
  logic [2*INT_W-1:0] wk_mem [2][N_PTS];
  logic [BUS_W-1:0] out_mem [2][N_STR][BEATS];

  // ==========================================================
  // input side state
  logic [CNT_W-1:0] icnt_q [N_STR];
  logic [CNT_W-1:0] icnt_d [N_STR];
  logic [N_STR-1:0] irdy_q;
  logic [N_STR-1:0] irdy_d;
  logic [N_STR-1:0] iacc;
  logic [1:0] in_full_q;
  logic [1:0] in_full_d;
  logic in_wb_q;
  logic frame_in;

  // ==========================================================
  // engine state
  sidf_cstate_t cst_q;
  logic [STG_W-1:0] st_q;
  logic [IDX_W-1:0] p_q;
  logic [IDX_W-1:0] q_q;
  logic [1:0] j_q;
  logic [1:0] i_q;
  logic crb_q;
  logic cwb_q;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_im_q;
  logic [1:0] r_m1;
  logic [IDX_W-1:0] s_m1;
  logic [IDX_W-1:0] m_m1;
  logic i_last;
  logic j_last;
  logic q_last;
  logic p_last;
  logic run;
  logic wr_en;
  logic stg_end;
  logic rel_in;
  logic [ADR_W-1:0] src_x;
  logic [ADR_W-1:0] dst_x;
  logic [ADR_W-1:0] exp_x;
  logic [IDX_W-1:0] src;
  logic [IDX_W-1:0] dst;
  logic [INT_W-1:0] smp;
  logic signed [INT_W-1:0] x_re;
  logic signed [INT_W-1:0] x_im;
  logic signed [PROD_W-1:0] p_re;
  logic signed [PROD_W-1:0] p_im;
  logic signed [ACC_W-1:0] sum_re;
  logic signed [ACC_W-1:0] sum_im;
  logic signed [INT_W-1:0] res_re;
  logic signed [INT_W-1:0] res_im;
  logic signed [INT_W-1:0] sh_re;
  logic signed [INT_W-1:0] sh_im;
  logic [SMP_W-1:0] o_re;
  logic [SMP_W-1:0] o_im;

  // ==========================================================
  // output side state
  logic [1:0] out_full_q;
  logic [1:0] out_full_d;
  logic ob_q;
  logic [CNT_W-1:0] lcnt_q [N_STR];
  logic [N_STR-1:0] ov_q;
  logic [N_STR-1:0] ol_q;
  logic [BUS_W-1:0] od_q [N_STR];
  logic [N_STR-1:0] ld;
  logic drained;

  // ==========================================================
  // input acceptance: 64 beats of four samples fill one block per stream
  always_comb begin
    frame_in = 1'b1;
    for (int s = 0; s < N_STR; s++) begin
      iacc[s] = in_tvalid[s] & irdy_q[s];
      icnt_d[s] = icnt_q[s] + CNT_W'(iacc[s]);
      if (icnt_d[s] != CNT_W'(BEATS))
        frame_in = 1'b0; // see (RL8)
    end
    in_full_d = in_full_q;
    if (rel_in)
      in_full_d[crb_q] = 1'b0;
    // a completing frame sets its bank after any release
    if (frame_in)
      in_full_d[in_wb_q] = 1'b1;
    for (int s = 0; s < N_STR; s++) begin
      if (frame_in)
        irdy_d[s] = !in_full_d[!in_wb_q];
      else
        irdy_d[s] = !in_full_d[in_wb_q] && icnt_d[s] != CNT_W'(BEATS);
    end
  end

  // input counters, bank flags and ready flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < N_STR; s++)
        icnt_q[s] <= '0;
      irdy_q <= '0;
      in_full_q <= 2'h0;
      in_wb_q <= 1'b0;
    end else begin
      for (int s = 0; s < N_STR; s++)
        icnt_q[s] <= frame_in ? '0 : icnt_d[s];
      irdy_q <= irdy_d; // see (RL6)
      in_full_q <= in_full_d;
      if (frame_in)
        in_wb_q <= !in_wb_q; // next frame fills while this one computes, see (RL7)
    end
  end
  assign in_tready = irdy_q;

  // ==========================================================
  // engine addressing; generalised self-sorting passes
  always_comb begin
    r_m1 = 2'(STG_RADIX[st_q] - 1);
    s_m1 = IDX_W'(STG_SPAN[st_q] - 1);
    m_m1 = IDX_W'(STG_M[st_q] - 1);
    i_last = i_q == r_m1;
    j_last = j_q == r_m1;
    q_last = q_q == s_m1;
    p_last = p_q == m_m1;
    run = cst_q == C_RUN;
    wr_en = run && i_last;
    stg_end = wr_en && j_last && q_last && p_last;
    rel_in = stg_end && st_q == '0;
    // input element i of group (p,q), output element j; see (RL1)
    src_x = ADR_W'(q_q) + ADR_W'(STG_SPAN[st_q])
      * (ADR_W'(p_q) + ADR_W'(i_q) * ADR_W'(STG_M[st_q]));
    dst_x = ADR_W'(q_q) + ADR_W'(STG_SPAN[st_q])
      * (ADR_W'(STG_RADIX[st_q]) * ADR_W'(p_q) + ADR_W'(j_q));
    exp_x = (ADR_W'(j_q) * (ADR_W'(i_q) * ADR_W'(STG_M[st_q])
      + ADR_W'(p_q)) * ADR_W'(STG_SPAN[st_q])) % ADR_W'(N_PTS);
    src = src_x[IDX_W-1:0];
    dst = dst_x[IDX_W-1:0];
  end

  // operand fetch: first pass widens 16-bit samples, see (RL4)
  always_comb begin
    smp = in_mem[crb_q][src[10:8]][src[7:2]][{src[1:0], 5'h0} +: INT_W];
    if (st_q == '0) begin
      x_re = INT_W'(signed'(smp[SMP_W-1:0]));
      x_im = INT_W'(signed'(smp[INT_W-1:SMP_W]));
    end else begin
      x_re = signed'(wk_mem[!st_q[0]][src][INT_W-1:0]);
      x_im = signed'(wk_mem[!st_q[0]][src][2*INT_W-1:INT_W]);
    end
  end

  sidf_cmul u_cmul (
    .expo (exp_x[IDX_W-1:0]),
    .x_re (x_re),
    .x_im (x_im),
    .p_re (p_re),
    .p_im (p_im)
  );

  // accumulate r products, drop the twiddle fraction on write
  always_comb begin
    sum_re = (i_q == '0 ? '0 : acc_q) + ACC_W'(p_re);
    sum_im = (i_q == '0 ? '0 : acc_im_q) + ACC_W'(p_im);
    res_re = INT_W'(sum_re >>> TW_FRAC);
    res_im = INT_W'(sum_im >>> TW_FRAC);
    // fixed 1/2048 output scale with saturation, see (RL9)
    sh_re = res_re >>> OUT_SHIFT;
    sh_im = res_im >>> OUT_SHIFT;
    if (sh_re[INT_W-1:SMP_W-1] == '0 || sh_re[INT_W-1:SMP_W-1] == '1)
      o_re = sh_re[SMP_W-1:0];
    else
      o_re = sh_re[INT_W-1] ? 16'h8000 : 16'h7FFF;
    if (sh_im[INT_W-1:SMP_W-1] == '0 || sh_im[INT_W-1:SMP_W-1] == '1)
      o_im = sh_im[SMP_W-1:0];
    else
      o_im = sh_im[INT_W-1] ? 16'h8000 : 16'h7FFF;
  end

  // ==========================================================
  // engine sequencer: passes 4,4,4,4 then 2 then 3
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cst_q <= C_IDLE;
      st_q <= '0;
      p_q <= '0;
      q_q <= '0;
      j_q <= 2'h0;
      i_q <= 2'h0;
      crb_q <= 1'b0;
      cwb_q <= 1'b0;
      acc_q <= '0;
      acc_im_q <= '0;
    end else begin
      case (cst_q)
        C_IDLE: begin
          // start only with a full frame and a free result bank
          if (in_full_q[crb_q] && !out_full_q[cwb_q]) begin
            cst_q <= C_RUN;
            st_q <= '0;
          end
        end
        C_RUN: begin
          acc_q <= sum_re;
          acc_im_q <= sum_im;
          if (!i_last) begin
            i_q <= i_q + 2'h1;
          end else begin
            i_q <= 2'h0;
            if (!j_last) begin
              j_q <= j_q + 2'h1;
            end else begin
              j_q <= 2'h0;
              if (!q_last) begin
                q_q <= q_q + 11'h001;
              end else begin
                q_q <= '0;
                if (!p_last) begin
                  p_q <= p_q + 11'h001;
                end else begin
                  p_q <= '0;
                  if (st_q == 0)
                    crb_q <= !crb_q;
                  if (st_q == STG_W'(N_STG - 1))
                    cst_q <= C_FIN; // 3-point pass closes, see (RL2)
                  else
                    st_q <= st_q + 3'h1; // four radix-4 then radix-2, see (RL3)
                end
              end
            end
          end
        end
        C_FIN: begin
          cwb_q <= !cwb_q;
          cst_q <= C_IDLE;
        end
        default: cst_q <= C_IDLE;
      endcase
    end
  end

  // ==========================================================
  // memory writes; no reset on storage arrays
  always_ff @(posedge mclk) begin
    for (int s = 0; s < N_STR; s++) begin
      if (iacc[s])
        in_mem[in_wb_q][s][icnt_q[s][5:0]] <= in_tdata[s]; // see (RL5)
    end
    if (wr_en && st_q != STG_W'(N_STG - 1))
      wk_mem[st_q[0]][dst] <= {res_im, res_re}; // 32-bit parts, see (RL4)
    if (wr_en && st_q == STG_W'(N_STG - 1))
      out_mem[cwb_q][dst[10:8]][dst[7:2]][{dst[1:0], 5'h0} +: INT_W]
        <= {o_im, o_re};
  end

  // ==========================================================
  // output streaming: registered source, reload on accept
  always_comb begin
    drained = out_full_q[ob_q];
    for (int s = 0; s < N_STR; s++) begin
      ld[s] = (!ov_q[s] || out_tready[s]) && out_full_q[ob_q]
        && lcnt_q[s] != CNT_W'(BEATS);
      if (lcnt_q[s] != CNT_W'(BEATS) || (ov_q[s] && !out_tready[s]))
        drained = 1'b0;
    end
    out_full_d = out_full_q;
    if (drained)
      out_full_d[ob_q] = 1'b0;
    // a finished frame wins over a release in the same cycle
    if (cst_q == C_FIN)
      out_full_d[cwb_q] = 1'b1;
  end

  // six output blocks drain in parallel with the next compute, see (RL7)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_full_q <= 2'h0;
      ob_q <= 1'b0;
      ov_q <= '0;
      ol_q <= '0;
      for (int s = 0; s < N_STR; s++) begin
        lcnt_q[s] <= '0;
        od_q[s] <= '0;
      end
    end else begin
      out_full_q <= out_full_d;
      if (drained)
        ob_q <= !ob_q;
      for (int s = 0; s < N_STR; s++) begin
        if (ld[s]) begin
          od_q[s] <= out_mem[ob_q][s][lcnt_q[s][5:0]]; // see (RL6)
          ov_q[s] <= 1'b1;
          ol_q[s] <= lcnt_q[s] == CNT_W'(BEATS - 1); // see (RL8)
          lcnt_q[s] <= lcnt_q[s] + 7'h01;
        end else if (out_tready[s]) begin
          ov_q[s] <= 1'b0;
        end
        if (drained)
          lcnt_q[s] <= '0;
      end
    end
  end
  assign out_tdata = od_q;
  assign out_tvalid = ov_q;
  assign out_tlast = ol_q;

endmodule

// ### sidf_chk_asserts.sv
// checker: stream handshake and framing properties of the transform
`timescale 1ns/100ps
module sidf_chk
  import sidf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // input streams
  input wire logic [BUS_W-1:0] in_tdata [N_STR],
  input wire logic [N_STR-1:0] in_tvalid,
  input wire logic [N_STR-1:0] in_tready,
  // output streams
  input wire logic [BUS_W-1:0] out_tdata [N_STR],
  input wire logic [N_STR-1:0] out_tvalid,
  input wire logic [N_STR-1:0] out_tlast,
  input wire logic [N_STR-1:0] out_tready
);
  // ==========================================================
  // beat counters
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [6:0] ci_q [N_STR];
  logic [5:0] co_q [N_STR];
  logic [N_STR-1:0] acc;
  logic all_in;
  // a frame is complete once every stream holds its full block
  always_comb begin
    acc = in_tvalid & in_tready;
    all_in = 1'b1;
    for (int s = 0; s < N_STR; s++) begin
      all_in &= (ci_q[s] + 7'(acc[s])) == 7'(BEATS);
    end
  end
  // counters follow the raw reset, the design's copy lags two edges
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ci_q <= '{default: 7'h00};
      co_q <= '{default: 6'h00};
    end else begin
      for (int s = 0; s < N_STR; s++) begin
        ci_q[s] <= all_in ? 7'h00 : ci_q[s] + 7'(acc[s]);
        co_q[s] <= co_q[s] + 6'(out_tvalid[s] & out_tready[s]);
      end
    end
  end
  // per-stream rules
  for (genvar s = 0; s < N_STR; s++) begin : g_s
    out_hold_a: assert property (
      out_tvalid[s] && !out_tready[s] |=> out_tvalid[s] &&
      $stable(out_tdata[s]) && $stable(out_tlast[s]))
      else $error("output beat changed before accept");
    last_pos_a: assert property (
      out_tvalid[s] |-> out_tlast[s] == (co_q[s] == 6'h3F))
      else $error("last flag on wrong beat");
    in_block_a: assert property (
      ci_q[s] == 7'(BEATS) |-> !in_tready[s])
      else $error("input taken past full block");
    no_bubble_a: assert property (
      out_tvalid[s] && out_tready[s] && !out_tlast[s] |=> out_tvalid[s])
      else $error("gap inside output block");
    ready_stand_a: assert property (
      ci_q[s] < 7'(BEATS) && in_tready[s] && !in_tvalid[s] |=> in_tready[s])
      else $error("input ready dropped early");
  end
  ready_late_a: assert property (
    $rose(reset_n) |-> (in_tready == '0)[*3] ##1 (&in_tready))
    else $error("input ready timing after reset");
  quiet_start_a: assert property (
    $rose(reset_n) |-> (out_tvalid == '0)[*8])
    else $error("output valid too soon after reset");
  frame_rise_a: assert property (
    $rose(out_tvalid[0]) |-> &out_tvalid)
    else $error("output streams start apart");
  cover property (ci_q[0] == 7'(BEATS) && !in_tready[0]);
  cover property (out_tvalid[0] && !out_tready[0]);
  cover property (out_tlast[5] && out_tready[5]);
endmodule

bind sidf_top sidf_chk chk_u (
  .mclk(mclk),
  .reset_n(reset_n),
  .in_tdata(in_tdata),
  .in_tvalid(in_tvalid),
  .in_tready(in_tready),
  .out_tdata(out_tdata),
  .out_tvalid(out_tvalid),
  .out_tlast(out_tlast),
  .out_tready(out_tready)
);

// ### sidf_fab_model.sv
// model: fabric logic stimulus source and result sink
`timescale 1ns/100ps
module sidf_fab_model
  import sidf_pkg::*;
(
  // clock
  input wire logic mclk,
  // source side
  output logic [BUS_W-1:0] in_tdata [N_STR],
  output logic [N_STR-1:0] in_tvalid,
  input wire logic [N_STR-1:0] in_tready,
  // sink side
  input wire logic [BUS_W-1:0] out_tdata [N_STR],
  input wire logic [N_STR-1:0] out_tvalid,
  input wire logic [N_STR-1:0] out_tlast,
  output logic [N_STR-1:0] out_tready
);
  // ==========================================================
  // sink: collects natural-order results per frame
  logic [31:0] rx [2][N_PTS];
  int ob [N_STR];
  int nfr = 0;
  int tot = 0;
  int tick = 0;
  bit sink_slow = 0;
  bit early_ok;
  bit early_bad;
  bit last_bad = 0;
  initial begin
    in_tvalid = '0;
    out_tready = '0;
    in_tdata = '{default: '0};
  end
  // index k = 256*s + 4*b + l, frame ends after all six blocks
  always @(posedge mclk) begin
    for (int s = 0; s < N_STR; s++) begin
      if (out_tvalid[s] && out_tready[s]) begin
        for (int l = 0; l < LANES; l++) begin
          rx[nfr % 2][256*s+4*ob[s]+l] = out_tdata[s][32*l+:32];
        end
        if (out_tlast[s] != (ob[s] == BEATS - 1)) last_bad = 1;
        ob[s]++;
        tot++;
      end
    end
    if (tot == N_STR * BEATS) begin
      nfr++;
      tot = 0;
      ob = '{default: 0};
    end
  end
  // slow sink stalls one cycle in three
  always @(negedge mclk) begin
    tick++;
    out_tready <= (sink_slow && tick % 3 == 0) ? '0 : '1;
  end
  // source: stream 0 full rate, others gap when slow; held until taken
  task automatic send(input int c, input int a, input int m, input bit slow);
    int b [N_STR];
    bit g [N_STR];
    int left;
    early_ok = 0;
    early_bad = 0;
    do begin
      @(negedge mclk);
      left = 0;
      for (int s = 0; s < N_STR; s++) begin
        if (b[s] < BEATS) left++;
        in_tvalid[s] <= !g[s] && b[s] < BEATS;
        if (g[s] || b[s] == BEATS) begin
          in_tdata[s] <= ~in_tdata[s];
        end else begin
          for (int l = 0; l < LANES; l++) begin
            in_tdata[s][32*l+:32] <= {16'h0000,
              16'(c + ((256*s + 4*b[s] + l) == m ? a : 0))};
          end
        end
        g[s] = 0;
      end
      @(posedge mclk);
      if (b[0] == BEATS && b[1] < BEATS) begin
        if (in_tready[0]) early_bad = 1;
        else early_ok = 1;
      end
      for (int s = 0; s < N_STR; s++) begin
        if (in_tvalid[s] && in_tready[s]) begin
          b[s]++;
          g[s] = slow && s > 0;
        end
      end
    end while (left > 0);
  endtask
endmodule

// ### testbench.sv
// testbench: frames through the parallel-stream inverse transform
`timescale 1ns/100ps
module testbench
  import sidf_pkg::*;
;
  // ==========================================================
  // signals and instances
  // e0 is the expected real value of bin zero: (a + 1536*c) / 2048
  typedef struct {int c; int a; int m; bit slow; int e0;} sidf_row_t;
  sidf_row_t rows [2] = '{'{1000, 20480, 257, 0, 760},
    '{-500, -10240, 1535, 1, -380}};
  logic mclk = 0;
  logic reset_n = 0;
  logic [BUS_W-1:0] in_tdata [N_STR];
  logic [N_STR-1:0] in_tvalid;
  logic [N_STR-1:0] in_tready;
  logic [BUS_W-1:0] out_tdata [N_STR];
  logic [N_STR-1:0] out_tvalid;
  logic [N_STR-1:0] out_tlast;
  logic [N_STR-1:0] out_tready;
  int n_errors = 0;
  int checks = 0;
  real ang;
  always #4 mclk = ~mclk;
  sidf_top dut_u (.mclk(mclk), .reset_n(reset_n), .in_tdata(in_tdata),
    .in_tvalid(in_tvalid), .in_tready(in_tready), .out_tdata(out_tdata),
    .out_tvalid(out_tvalid), .out_tlast(out_tlast), .out_tready(out_tready));
  sidf_fab_model fab_u (.mclk(mclk), .in_tdata(in_tdata),
    .in_tvalid(in_tvalid), .in_tready(in_tready), .out_tdata(out_tdata),
    .out_tvalid(out_tvalid), .out_tlast(out_tlast), .out_tready(out_tready));
  // tolerance covers truncated twiddles and floor scaling
  task automatic check(input string nm, input logic [15:0] seen,
                       input int exp, input int tol);
    checks++;
    if (^seen === 1'bx || $signed(seen) - exp > tol ||
        exp - $signed(seen) > tol) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp,
               $signed(seen));
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reset holds outputs quiet; ready comes back on the third edge
  task automatic rst_chk;
    reset_n <= 0;
    repeat (16) @(negedge mclk);
    check("ready in reset", 16'(in_tready), 0, 0);
    check("valid in reset", 16'(out_tvalid), 0, 0);
    check("data in reset", out_tdata[0][15:0], 0, 0);
    reset_n <= 1;
    repeat (2) @(negedge mclk);
    check("ready early", 16'(in_tready), 0, 0);
    @(negedge mclk);
    check("ready late", 16'(in_tready), 63, 0);
  endtask
  // ==========================================================
  // main sequence: two frames back to back, then a second reset
  initial begin
    rst_chk();
    for (int i = 0; i < 2; i++) begin
      fab_u.send(rows[i].c, rows[i].a, rows[i].m, rows[i].slow);
    end
    @(negedge mclk);
    check("ready both busy", 16'(in_tready), 0, 0);
    check("early refused", 16'(fab_u.early_ok), 1, 0);
    check("early taken", 16'(fab_u.early_bad), 0, 0);
    for (int i = 0; i < 2; i++) begin
      fab_u.sink_slow = rows[i].slow;
      for (int w = 0; w < 40000 && fab_u.nfr <= i; w++) @(negedge mclk);
      check("frame done", 16'(fab_u.nfr > i), 1, 0);
      check("dc real", fab_u.rx[i][0][15:0], rows[i].e0, 2);
      for (int k = 0; k < N_PTS; k++) begin
        ang = 2.0 * PI * rows[i].m * k / N_PTS;
        check("real", fab_u.rx[i][k][15:0], int'((rows[i].a * $cos(ang) +
          (k == 0 ? 1536.0 * rows[i].c : 0.0)) / 2048.0), 2);
        check("imag", fab_u.rx[i][k][31:16],
          int'(rows[i].a * $sin(ang) / 2048.0), 2);
      end
    end
    check("last flag", 16'(fab_u.last_bad), 0, 0);
    rst_chk();
    final_report();
  end
  // watchdog about a quarter beyond two frames of compute
  initial begin
    #640000;
    n_errors++;
    final_report();
  end
endmodule
